// file: hdl/misc_option_defines.vh
// Offsets, field positions, reset values and timing for the option register bank
`ifndef MISC_OPTION_DEFINES_VH
`define MISC_OPTION_DEFINES_VH
`define OFS_FAULT_POLICY 8'h7B
`define OFS_IFACE_LIMIT 8'h7C
`define OFS_CONV_LIMIT 8'h7D
`define RST_FAULT_POLICY 8'h00
`define RST_IFACE_LIMIT 8'h00
`define RST_CONV_LIMIT 8'h00
`define ADDR_PRIMARY 7'h4D
`define ADDR_ALTERNATE 7'h4E
`define CRC8_POLY 8'h07
`define FP_RETRY_HI 7
`define FP_RETRY_LO 6
`define FP_UVPRE_HI 5
`define FP_UVPRE_LO 4
`define FP_PHASE3 0
`define IL_ADDR_SEL 7
`define IL_MANUAL 6
`define IL_FILT30 5
`define IL_CRC 4
`define IL_SHORT_PULSE 3
`define IL_NOC1 2
`define IL_OC1_HI 1
`define IL_OC1_LO 0
`define CL_OCA_HI 7
`define CL_OCA_LO 6
`define CL_OCB_HI 5
`define CL_OCB_LO 4
`define CL_NOC_SS 2
`define RETRY_TEN 4'hA
`define RETRY_FIVE 4'h5
`define CLK_MHZ 100
`define UV_BUILTIN_NS 2000
`define UV_PRE1_US 10
`define UV_PRE2_US 25
`define UV_PRE3_US 40
`define UV_BUILTIN_CYC (`UV_BUILTIN_NS * `CLK_MHZ / 1000)
`define UV_PRE1_CYC (`UV_PRE1_US * `CLK_MHZ)
`define UV_PRE2_CYC (`UV_PRE2_US * `CLK_MHZ)
`define UV_PRE3_CYC (`UV_PRE3_US * `CLK_MHZ)
`define FILT30_MS 30
`define PULSE_LONG_MS 200
`define PULSE_SHORT_MS 20
`define MS_CYC(ms) ((ms) * `CLK_MHZ * 1000)
`endif

// file: hdl/misc_option_regs.v
// Option register bank with its I2C target, fault filters and fault pulse
`timescale 1ns/1ps
`default_nettype none
`include "misc_option_defines.vh"
module misc_option_regs #(
    parameter [22:0] FILT30_CYC = `MS_CYC(`FILT30_MS),
    parameter [24:0] PULSE_LONG_CYC = `MS_CYC(`PULSE_LONG_MS),
    parameter [24:0] PULSE_SHORT_CYC = `MS_CYC(`PULSE_SHORT_MS)
) (
    input wire clock,
    input wire rst_n,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire standby,
    input wire [3:0] uv_raw,
    input wire [3:0] ov_raw,
    input wire watchdog_fault,
    input wire sequence_fault,
    output reg [3:0] uv_fault,
    output reg [3:0] ov_fault,
    output reg fault_out_n,
    output reg [3:0] retry_limit,
    output reg latch_on_first,
    output reg third_converter_in_phase,
    output reg i2c_output_control,
    output reg negative_overcurrent_limit_1a,
    output reg [1:0] first_converter_overcurrent,
    output reg [1:0] third_converter_overcurrent_a,
    output reg [1:0] third_converter_overcurrent_b,
    output reg noc_soft_start_only,
    output reg [7:0] fault_policy_q,
    output reg [7:0] iface_limit_q,
    output reg [7:0] conv_limit_q
);
    localparam S_IDLE = 3'd0;
    localparam S_RX = 3'd1;
    localparam S_ACK = 3'd2;
    localparam S_TX = 3'd3;
    localparam S_TXACK = 3'd4;
    localparam [22:0] UV_BUILTIN = `UV_BUILTIN_CYC;
    localparam [22:0] UV_PRE1 = `UV_PRE1_CYC;
    localparam [22:0] UV_PRE2 = `UV_PRE2_CYC;
    localparam [22:0] UV_PRE3 = `UV_PRE3_CYC;

    function [7:0] crc8;
        input [7:0] crc;
        input [7:0] data;
        integer k;
        reg [7:0] c;
        begin
            c = crc ^ data;
            for (k = 0; k < 8; k = k + 1) begin
                c = c[7] ? ((c << 1) ^ `CRC8_POLY) : (c << 1);
            end
            crc8 = c;
        end
    endfunction

    // Code 3 is reserved and falls back to the default limit
    function [1:0] limit_code;
        input [1:0] code;
        begin
            limit_code = (code == 2'b11) ? 2'b00 : code;
        end
    endfunction

    // ************************************
    // Pin synchronisers
    // ************************************
    reg [1:0] scl_sy, sda_sy, stb_sy;
    reg [3:0] uv_m, uv_s, ov_m, ov_s;
    reg scl_p, sda_p;
    always @(posedge clock) begin
        if (!rst_n) begin
            scl_sy <= 2'b11;
            sda_sy <= 2'b11;
            stb_sy <= 2'b00;
            uv_m <= 4'h0;
            uv_s <= 4'h0;
            ov_m <= 4'h0;
            ov_s <= 4'h0;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_sy <= {scl_sy[0], scl_in};
            sda_sy <= {sda_sy[0], sda_in};
            stb_sy <= {stb_sy[0], standby};
            uv_m <= uv_raw;
            uv_s <= uv_m;
            ov_m <= ov_raw;
            ov_s <= ov_m;
            scl_p <= scl_sy[1];
            sda_p <= sda_sy[1];
        end
    end
    wire scl = scl_sy[1];
    wire sda = sda_sy[1];
    wire scl_rise = scl & ~scl_p;
    wire scl_fall = ~scl & scl_p;
    wire start_c = scl & scl_p & sda_p & ~sda;
    wire stop_c = scl & scl_p & ~sda_p & sda;

    // ************************************
    // I2C target and register file
    // ************************************
    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shreg, tx_sh, ptr, crc, wdata;
    reg [1:0] byte_idx;
    reg rw, acking, tx_crc_next, master_ack;
    wire crc_on = iface_limit_q[`IL_CRC];
    wire [6:0] my_addr = iface_limit_q[`IL_ADDR_SEL] ? `ADDR_ALTERNATE : `ADDR_PRIMARY;
    reg [7:0] rd_data;
    always @* begin
        case (ptr)
            `OFS_FAULT_POLICY: rd_data = fault_policy_q;
            `OFS_IFACE_LIMIT: rd_data = iface_limit_q;
            `OFS_CONV_LIMIT: rd_data = conv_limit_q;
            default: rd_data = 8'h00;
        endcase
    end
    wire [7:0] tx_byte = tx_crc_next ? crc8(crc, rd_data) : rd_data;

    task write_reg;
        input [7:0] d;
        begin
            if (stb_sy[1]) begin
                if (ptr == `OFS_FAULT_POLICY) fault_policy_q <= d;
                if (ptr == `OFS_IFACE_LIMIT) iface_limit_q <= d;
                if (ptr == `OFS_CONV_LIMIT) conv_limit_q <= d;
            end
        end
    endtask

    always @(posedge clock) begin
        if (!rst_n) begin
            state <= S_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            tx_sh <= 8'h00;
            ptr <= 8'h00;
            crc <= 8'h00;
            wdata <= 8'h00;
            byte_idx <= 2'd0;
            rw <= 1'b0;
            acking <= 1'b0;
            tx_crc_next <= 1'b0;
            master_ack <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            fault_policy_q <= `RST_FAULT_POLICY;
            iface_limit_q <= `RST_IFACE_LIMIT;
            conv_limit_q <= `RST_CONV_LIMIT;
        end else if (start_c) begin
            state <= S_RX;
            bit_cnt <= 4'h0;
            byte_idx <= 2'd0;
            sda_oe <= 1'b0;
        end else if (stop_c) begin
            state <= S_IDLE;
            sda_oe <= 1'b0;
        end else begin
            case (state)
                S_RX: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        acking <= 1'b1;
                        state <= S_ACK;
                        sda_oe <= 1'b1;
                        case (byte_idx)
                            2'd0: begin
                                if (shreg[7:1] == my_addr) begin
                                    rw <= shreg[0];
                                    crc <= crc8(8'h00, shreg);
                                    tx_crc_next <= 1'b0;
                                    byte_idx <= 2'd1;
                                end else begin
                                    state <= S_IDLE;
                                    sda_oe <= 1'b0;
                                end
                            end
                            2'd1: begin
                                ptr <= shreg;
                                crc <= crc8(crc, shreg);
                                byte_idx <= 2'd2;
                            end
                            2'd2: begin
                                if (crc_on) begin
                                    wdata <= shreg;
                                    crc <= crc8(crc, shreg);
                                    byte_idx <= 2'd3;
                                end else begin
                                    write_reg(shreg);
                                    ptr <= ptr + 8'h01;
                                end
                            end
                            default: begin
                                // Bad CRC is acknowledged but dropped; later bytes get no ACK
                                if (tx_crc_next) begin
                                    state <= S_IDLE;
                                    sda_oe <= 1'b0;
                                end else if (shreg == crc) begin
                                    write_reg(wdata);
                                end
                                tx_crc_next <= 1'b1;
                            end
                        endcase
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        acking <= 1'b0;
                        if (rw) begin
                            state <= S_TX;
                            sda_oe <= ~tx_byte[7];
                            tx_sh <= {tx_byte[6:0], 1'b0};
                            bit_cnt <= 4'h1;
                            if (crc_on) begin
                                tx_crc_next <= ~tx_crc_next;
                            end
                            if (!crc_on || tx_crc_next) begin
                                ptr <= ptr + 8'h01;
                            end
                            if (!tx_crc_next) begin
                                crc <= crc8(crc, rd_data);
                            end
                        end else begin
                            state <= S_RX;
                            sda_oe <= 1'b0;
                        end
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt == 4'h8) begin
                            sda_oe <= 1'b0;
                            state <= S_TXACK;
                        end else begin
                            sda_oe <= ~tx_sh[7];
                            tx_sh <= {tx_sh[6:0], 1'b0};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                S_TXACK: begin
                    if (scl_rise) begin
                        master_ack <= ~sda;
                    end else if (scl_fall) begin
                        if (master_ack) begin
                            state <= S_ACK;
                        end else begin
                            state <= S_IDLE;
                        end
                    end
                end
                default: begin
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // ************************************
    // Undervoltage and overvoltage filters
    // ************************************
    // Long filter stretches detection, so release is immediate to keep response bounded
    wire filt30 = iface_limit_q[`IL_FILT30];
    reg [22:0] uv_thr;
    always @* begin
        case (fault_policy_q[`FP_UVPRE_HI:`FP_UVPRE_LO])
            2'd1: uv_thr = UV_PRE1;
            2'd2: uv_thr = UV_PRE2;
            2'd3: uv_thr = UV_PRE3;
            default: uv_thr = 23'd0;
        endcase
        uv_thr = uv_thr + UV_BUILTIN + (filt30 ? FILT30_CYC : 23'd0);
    end
    wire [22:0] ov_thr = filt30 ? FILT30_CYC : 23'd0;
    reg [22:0] uv_cnt [0:3];
    reg [22:0] ov_cnt [0:3];
    reg [3:0] uvov_prev;
    integer i;
    always @(posedge clock) begin
        if (!rst_n) begin
            for (i = 0; i < 4; i = i + 1) begin
                uv_cnt[i] <= 23'd0;
                ov_cnt[i] <= 23'd0;
            end
            uv_fault <= 4'h0;
            ov_fault <= 4'h0;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                uv_cnt[i] <= (uv_s[i] && uv_cnt[i] < uv_thr) ? uv_cnt[i] + 23'd1 :
                             (uv_s[i] ? uv_cnt[i] : 23'd0);
                ov_cnt[i] <= (ov_s[i] && ov_cnt[i] < ov_thr) ? ov_cnt[i] + 23'd1 :
                             (ov_s[i] ? ov_cnt[i] : 23'd0);
                uv_fault[i] <= uv_s[i] && uv_cnt[i] >= uv_thr;
                ov_fault[i] <= ov_s[i] && ov_cnt[i] >= ov_thr;
            end
        end
    end

    // ************************************
    // Fault output pulse and decoded options
    // ************************************
    reg [24:0] pulse_cnt;
    wire [24:0] wdseq_len = iface_limit_q[`IL_SHORT_PULSE] ? PULSE_SHORT_CYC : PULSE_LONG_CYC;
    wire [3:0] uvov_now = uv_fault | ov_fault;
    wire uvov_evt = |(uvov_now & ~uvov_prev);
    always @(posedge clock) begin
        if (!rst_n) begin
            pulse_cnt <= 25'd0;
            uvov_prev <= 4'h0;
            fault_out_n <= 1'b1;
            retry_limit <= 4'h0;
            latch_on_first <= 1'b0;
            third_converter_in_phase <= 1'b0;
            i2c_output_control <= 1'b0;
            negative_overcurrent_limit_1a <= 1'b0;
            first_converter_overcurrent <= 2'b00;
            third_converter_overcurrent_a <= 2'b00;
            third_converter_overcurrent_b <= 2'b00;
            noc_soft_start_only <= 1'b0;
        end else begin
            uvov_prev <= uvov_now;
            // A new event never shortens a pulse already running
            if (uvov_evt && pulse_cnt < PULSE_LONG_CYC) begin
                pulse_cnt <= PULSE_LONG_CYC;
            end else if ((watchdog_fault || sequence_fault) && pulse_cnt < wdseq_len) begin
                pulse_cnt <= wdseq_len;
            end else if (pulse_cnt != 25'd0) begin
                pulse_cnt <= pulse_cnt - 25'd1;
            end
            fault_out_n <= ~(uvov_evt || watchdog_fault || sequence_fault || pulse_cnt > 25'd1);
            case (fault_policy_q[`FP_RETRY_HI:`FP_RETRY_LO])
                2'd1: retry_limit <= `RETRY_TEN;
                2'd2: retry_limit <= `RETRY_FIVE;
                default: retry_limit <= 4'h0;
            endcase
            latch_on_first <= &fault_policy_q[`FP_RETRY_HI:`FP_RETRY_LO];
            third_converter_in_phase <= fault_policy_q[`FP_PHASE3];
            i2c_output_control <= iface_limit_q[`IL_MANUAL];
            negative_overcurrent_limit_1a <= iface_limit_q[`IL_NOC1];
            first_converter_overcurrent <= limit_code(iface_limit_q[`IL_OC1_HI:`IL_OC1_LO]);
            third_converter_overcurrent_a <= limit_code(conv_limit_q[`CL_OCA_HI:`CL_OCA_LO]);
            third_converter_overcurrent_b <= limit_code(conv_limit_q[`CL_OCB_HI:`CL_OCB_LO]);
            noc_soft_start_only <= conv_limit_q[`CL_NOC_SS];
        end
    end
endmodule // misc_option_regs
`default_nettype wire

// file: tb/i2c_host.sv
// Behavioural I2C controller that configures the option bank
`timescale 1ns/1ps
`default_nettype none
module i2c_host (
    input wire logic clock,
    input wire logic sda,
    output logic scl,
    output logic sda_rel
);
    // ********
    // Bus phases
    // ********
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic half();
        repeat (8) @(negedge clock);
    endtask
    task automatic bitx(input logic b, output logic s);
        sda_rel = b;
        half();
        scl = 1'b1;
        half();
        s = sda;
        scl = 1'b0;
    endtask
    // Also serves as repeated start
    task automatic start();
        sda_rel = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_rel = 1'b0;
        half();
        scl = 1'b0;
    endtask
    task automatic stop();
        sda_rel = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_rel = 1'b1;
        half();
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(b[i], s);
        bitx(1'b1, s);
        ack = !s;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
        bitx(last, s);
    endtask
endmodule // i2c_host
`default_nettype wire

// file: tb/misc_option_checker.sv
// Port-level assertions for the option bank
`timescale 1ns/1ps
`default_nettype none
`include "misc_option_defines.vh"
module misc_option_checker (
    input wire clock,
    input wire rst_n,
    input wire standby,
    input wire [3:0] uv_raw,
    input wire [3:0] ov_raw,
    input wire [3:0] uv_fault,
    input wire [3:0] ov_fault,
    input wire fault_out_n,
    input wire [3:0] retry_limit,
    input wire latch_on_first,
    input wire [1:0] first_converter_overcurrent,
    input wire [1:0] third_converter_overcurrent_a,
    input wire [7:0] fault_policy_q,
    input wire [7:0] iface_limit_q,
    input wire [7:0] conv_limit_q
);
    // ********
    // Properties
    // ********
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    retry_ten_a: assert property (fault_policy_q[7:6] == 2'd1 |=>
        retry_limit == `RETRY_TEN && !latch_on_first) else $error("ten retries not decoded");
    retry_five_a: assert property (fault_policy_q[7:6] == 2'd2 |=>
        retry_limit == `RETRY_FIVE) else $error("five retries not decoded");
    latch_first_a: assert property (fault_policy_q[7:6] == 2'd3 |=>
        latch_on_first && retry_limit == 4'h0) else $error("latch-off not decoded");
    oc1_map_a: assert property (1'b1 |=> first_converter_overcurrent ==
        ($past(iface_limit_q[1:0]) == 2'd3 ? 2'd0 : $past(iface_limit_q[1:0])))
        else $error("first limit code wrong");
    conv_map_a: assert property (conv_limit_q[7:6] == 2'd3 |=>
        third_converter_overcurrent_a == 2'd0) else $error("reserved code not default");
    // Sync lag on standby leaves up to four clocks of slack
    standby_gate_a: assert property ($changed({fault_policy_q, iface_limit_q, conv_limit_q})
        |-> $past(standby) || $past(standby, 2) || $past(standby, 3) || $past(standby, 4))
        else $error("option write outside standby");
    ov_fast_a: assert property ((!iface_limit_q[5] && ov_raw[0]) [*8] |-> ov_fault[0])
        else $error("overvoltage detection delayed");
    uv_min_a: assert property ($rose(uv_fault[0]) |-> $past(uv_raw[0], 150))
        else $error("undervoltage flagged too early");
    cover property (latch_on_first);
    cover property ($fell(fault_out_n));
    cover property ($rose(uv_fault[0]));
endmodule // misc_option_checker
bind misc_option_regs misc_option_checker u_chk (.*);
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the option register bank
`timescale 1ns/1ps
`default_nettype none
`include "misc_option_defines.vh"
module tb;
    // ********
    // Harness
    // ********
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic standby = 1'b1;
    logic [3:0] uv_raw = 4'h0;
    logic [3:0] ov_raw = 4'h0;
    logic watchdog_fault = 1'b0;
    logic sequence_fault = 1'b0;
    wire scl, sda_rel, sda_oe, fault_out_n, latch_on_first, third_converter_in_phase;
    wire i2c_output_control, negative_overcurrent_limit_1a, noc_soft_start_only;
    wire sda = sda_rel & ~sda_oe;
    wire [3:0] uv_fault, ov_fault, retry_limit;
    wire [1:0] first_converter_overcurrent, third_converter_overcurrent_a;
    wire [1:0] third_converter_overcurrent_b;
    wire [7:0] fault_policy_q, iface_limit_q, conv_limit_q;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int pre [4] = '{0, `UV_PRE1_CYC, `UV_PRE2_CYC, `UV_PRE3_CYC};
    logic [7:0] model [3] = '{`RST_FAULT_POLICY, `RST_IFACE_LIMIT, `RST_CONV_LIMIT};
    logic [6:0] dev_addr = `ADDR_PRIMARY;
    logic [7:0] d, rb;
    logic ack;
    always #5 clock = ~clock;
    misc_option_regs #(.FILT30_CYC(23'd50), .PULSE_LONG_CYC(25'd40), .PULSE_SHORT_CYC(25'd8))
        u_dut (.*, .scl_in(scl), .sda_in(sda), .sda_out());
    i2c_host u_host (.clock(clock), .sda(sda), .scl(scl), .sda_rel(sda_rel));
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 90000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Sync pipeline adds a few clocks of unknown lag
    task automatic cmp_cnt(input string what, input int exp, input int got);
        n_tests++;
        if (got < exp - 2 || got > exp + 5) begin
            errors++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask
    function automatic logic [7:0] crc8(input logic [23:0] v);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? `CRC8_POLY : 8'h00);
        return c;
    endfunction
    function automatic logic [1:0] map2(input logic [1:0] c);
        return (c == 2'd3) ? 2'd0 : c;
    endfunction
    task automatic wr(input logic [6:0] a, input logic [7:0] off, input logic [7:0] dv,
                      input logic crc_on, input logic [7:0] crc_err, output logic ok);
        logic k0, k1, k2, k3;
        u_host.start();
        u_host.wbyte({a, 1'b0}, k0);
        u_host.wbyte(off, k1);
        u_host.wbyte(dv, k2);
        k3 = 1'b1;
        if (crc_on) u_host.wbyte(crc8({a, 1'b0, off, dv}) ^ crc_err, k3);
        u_host.stop();
        ok = k0 & k1 & k2 & k3;
        if (ok && standby && crc_err == 8'h00 && off >= 8'h7B && off <= 8'h7D) begin
            model[off - 8'h7B] = dv;
            if (off == `OFS_IFACE_LIMIT) dev_addr = dv[7] ? `ADDR_ALTERNATE : `ADDR_PRIMARY;
        end
    endtask
    task automatic w(input logic [7:0] off, input logic [7:0] dv);
        wr(dev_addr, off, dv, 1'b0, 8'h00, ack);
        cmp("write ack", 16'h1, {15'h0, ack});
    endtask
    task automatic rd(input logic [7:0] off, output logic [7:0] dv);
        logic k;
        u_host.start();
        u_host.wbyte({dev_addr, 1'b0}, k);
        u_host.wbyte(off, k);
        u_host.start();
        u_host.wbyte({dev_addr, 1'b1}, k);
        u_host.rbyte(1'b1, dv);
        u_host.stop();
    endtask
    task automatic chk_all();
        logic [3:0] rl;
        for (int i = 0; i < 3; i++) begin
            rd(8'h7B + i[7:0], rb);
            cmp("register read", {8'h00, model[i]}, {8'h00, rb});
        end
        cmp("raw 7B", {8'h00, model[0]}, {8'h00, fault_policy_q});
        cmp("raw 7C 7D", {model[1], model[2]}, {iface_limit_q, conv_limit_q});
        rl = (model[0][7:6] == 2'd1) ? `RETRY_TEN : (model[0][7:6] == 2'd2) ? `RETRY_FIVE : 4'h0;
        cmp("decoded", {1'b0, rl, model[0][7:6] == 2'd3, model[0][0], model[1][6], model[1][2],
            map2(model[1][1:0]), map2(model[2][7:6]), map2(model[2][5:4]), model[2][2]},
            {1'b0, retry_limit, latch_on_first, third_converter_in_phase, i2c_output_control,
            negative_overcurrent_limit_1a, first_converter_overcurrent,
            third_converter_overcurrent_a, third_converter_overcurrent_b,
            noc_soft_start_only});
    endtask
    task automatic lat(input logic ov, input int k, input int exp, input string what);
        int n;
        n = 0;
        if (ov) ov_raw[k] = 1'b1;
        else uv_raw[k] = 1'b1;
        while ((ov ? ov_fault[k] : uv_fault[k]) !== 1'b1 && n < 6000) begin
            @(negedge clock);
            n++;
        end
        cmp_cnt(what, exp, n);
        repeat (10) @(negedge clock);
        uv_raw = 4'h0;
        ov_raw = 4'h0;
        repeat (60) @(negedge clock);
    endtask
    task automatic pulse(input int sel, input int exp, input string what);
        int n;
        n = 0;
        watchdog_fault = (sel == 0);
        sequence_fault = (sel == 1);
        ov_raw[3] = (sel == 2);
        @(negedge clock);
        watchdog_fault = 1'b0;
        sequence_fault = 1'b0;
        while (fault_out_n !== 1'b0 && n < 20) begin
            @(negedge clock);
            n++;
        end
        n = 0;
        while (fault_out_n === 1'b0 && n < 300) begin
            @(negedge clock);
            n++;
        end
        ov_raw[3] = 1'b0;
        cmp_cnt(what, exp, n);
        repeat (10) @(negedge clock);
    endtask
    initial begin
        void'($urandom(13328));
        repeat (20) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        chk_all();
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            w(`OFS_FAULT_POLICY, {i[1:0], d[5:0]});
            w(`OFS_IFACE_LIMIT, {1'b0, d[6:5], 1'b0, d[3:2], i[1:0]});
            w(`OFS_CONV_LIMIT, {i[1:0], ~i[1:0], d[3:0]});
            chk_all();
        end
        standby = 1'b0;
        repeat (8) @(negedge clock);
        w(`OFS_CONV_LIMIT, 8'hA5);
        standby = 1'b1;
        chk_all();
        w(8'h7E, 8'($urandom));
        rd(8'h7E, rb);
        cmp("unmapped read", 16'h0000, {8'h00, rb});
        w(`OFS_IFACE_LIMIT, 8'h10);
        wr(dev_addr, `OFS_FAULT_POLICY, 8'h5A, 1'b1, 8'h01, ack);
        wr(dev_addr, `OFS_FAULT_POLICY, 8'hC3, 1'b1, 8'h00, ack);
        wr(dev_addr, `OFS_IFACE_LIMIT, 8'h00, 1'b1, 8'h00, ack);
        chk_all();
        w(`OFS_IFACE_LIMIT, 8'h80);
        wr(`ADDR_PRIMARY, `OFS_FAULT_POLICY, 8'hFF, 1'b0, 8'h00, ack);
        cmp("old address ack", 16'h0, {15'h0, ack});
        chk_all();
        w(`OFS_IFACE_LIMIT, 8'h00);
        for (int k = 0; k < 4; k++) begin
            w(`OFS_FAULT_POLICY, {2'b00, k[1:0], 4'h0});
            lat(1'b0, k, `UV_BUILTIN_CYC + pre[k], "uv delay");
        end
        lat(1'b1, 0, 0, "ov delay");
        w(`OFS_IFACE_LIMIT, 8'h20);
        lat(1'b1, 1, 50, "ov filtered delay");
        lat(1'b0, 2, `UV_BUILTIN_CYC + `UV_PRE3_CYC + 50, "uv filtered delay");
        w(`OFS_IFACE_LIMIT, 8'h00);
        pulse(0, 40, "long pulse");
        w(`OFS_IFACE_LIMIT, 8'h08);
        pulse(1, 8, "sequence pulse");
        pulse(0, 8, "watchdog pulse");
        pulse(2, 40, "ov pulse");
        give_verdict();
    end
endmodule // tb
`default_nettype wire
